//--- tmr8_core.sv
// 8-bit timer/counter with compare output, clock select, flags and APB registers.
// Functional notes
// - A nonzero output action mode hands the pin to the compare output.
// - The compare output drives the pin only while the port direction is output.
// - Normal and CTC: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 00 off, 01 reserved, 10 clear/set-at-top, 11 set/clear-at-top.
// - Dual-slope PWM: 10 clears counting up, sets counting down; 11 reverse.
// - PWM with compare at top and upper mode bit: act at top, ignore match.
// - Clock select 000 stops, 001 undivided, 010 to 101 prescaler taps.
// - Clock select 110 counts falling, 111 rising external pin edges.
// - External pin edges count even when the pin is an output.
// - Software reads and writes the 8-bit count directly.
// - A count write suppresses the compare match on the next timer tick.
// - Compare value is checked against the count every cycle.
// - The match flag sets when the count equals the compare value on a timer tick not blocked by a count write.
// - Match flag clears on vector or written one; irq is flag, enable, global.
// - Overflow flag sets on overflow, clears likewise; irq gated the same way.
// - In dual-slope PWM the overflow flag sets on turning at zero.
// - One shared prescaler; each timer keeps its own clock select.
// - Waveform mode: 0 normal, 1 dual-slope, 2 CTC, 3 fast PWM.
//
// Our own choices: the register addresses and register access over APB.
`default_nettype none
`include "tmr8_params.svh"
module tmr8_core
	import tmr8_pkg::*;
(
	// Clock and reset.
	input  wire logic                     core_clk_i,
	input  wire logic                     rstn_i,
	// APB slave.
	input  wire logic [`TMR8_ADDR_W-1:0]  paddr_i,
	input  wire logic                     psel_i,
	input  wire logic                     penable_i,
	input  wire logic                     pwrite_i,
	input  wire logic [31:0]              pwdata_i,
	output var  logic [31:0]              prdata_o,
	output      logic                     pready_o,
	output      logic                     pslverr_o,
	// Port pin driver.
	input  wire logic                     port_dir_i,
	input  wire logic                     port_data_i,
	output var  logic                     compare_output_pin_o,
	output var  logic                     compare_output_pin_oe_o,
	// External count source and shared prescaler.
	input  wire logic                     external_count_pin_i,
	input  wire logic                     prescale_clear_i,
	output      logic [`TMR8_TAP1024_BITS-1:0] prescale_count_o,
	// Interrupt controller.
	input  wire logic                     global_irq_enable_i,
	input  wire logic                     match_irq_ack_i,
	input  wire logic                     overflow_irq_ack_i,
	output      logic                     match_irq_o,
	output      logic                     overflow_irq_o,
	// Events for the rest of the unit.
	output      logic                     match_event_o,
	output      logic                     top_event_o,
	output      logic                     bottom_event_o
);
	// ************************************************************
	// Declarations
	// ************************************************************
	tmr8_wave_t  waveform_mode;
	tmr8_out_t   output_action_mode;
	tmr8_cs_t    clock_source_select;
	logic [7:0]  count_value;
	logic [7:0]  compare_value;
	logic        match_irq_enable;
	logic        overflow_irq_enable;
	logic        match_flag;
	logic        overflow_flag;
	logic        count_down;
	logic        match_block;
	logic        compare_out;
	logic [7:0]  next_count;
	logic        next_down;
	logic        next_out;
	logic [7:0]  top_value;
	logic [7:0]  read_byte;
	logic        tick;
	logic        setup;
	logic        access;
	logic        mapped;
	logic        wr_control;
	logic        wr_count;
	logic        wr_compare;
	logic        wr_mask;
	logic        wr_flags;
	logic        force_match;
	logic        match_hit;
	logic        top_hit;
	logic        ovf_hit;
	logic        pwm_mode;
	logic        top_ignore;

	// ************************************************************
	// Clock source
	// ************************************************************
	tmr8_tick_if tick_bus ();

	// Each timer owns its select; the prescaler count is exported for a sibling.
	assign tick_bus.select  = clock_source_select;
	assign tick             = tick_bus.tick;
	assign prescale_count_o = tick_bus.prescale;

	tmr8_clock_select u_clock_select (
		.core_clk_i           (core_clk_i),
		.rstn_i               (rstn_i),
		.external_count_pin_i (external_count_pin_i),
		.prescale_clear_i     (prescale_clear_i),
		.tif                  (tick_bus.source)
	);

	// ************************************************************
	// APB slave
	// ************************************************************
	// Zero wait states; an unmapped address answers with an error.
	assign setup     = psel_i && !penable_i;
	assign access    = psel_i && penable_i;
	assign pready_o  = 1'b1;
	assign mapped    = (paddr_i == `TMR8_OFS_CONTROL) || (paddr_i == `TMR8_OFS_COUNT) ||
	                   (paddr_i == `TMR8_OFS_COMPARE) || (paddr_i == `TMR8_OFS_MASK) ||
	                   (paddr_i == `TMR8_OFS_FLAGS);
	assign pslverr_o = access && !mapped;

	// Write strobes, valid at the completing edge only.
	assign wr_control = access && pwrite_i && (paddr_i == `TMR8_OFS_CONTROL);
	assign wr_count   = access && pwrite_i && (paddr_i == `TMR8_OFS_COUNT);
	assign wr_compare = access && pwrite_i && (paddr_i == `TMR8_OFS_COMPARE);
	assign wr_mask    = access && pwrite_i && (paddr_i == `TMR8_OFS_MASK);
	assign wr_flags   = access && pwrite_i && (paddr_i == `TMR8_OFS_FLAGS);

	// Read mux; the force bit always reads as zero.
	always_comb
	begin
		read_byte = 8'h00;
		case (paddr_i)
			`TMR8_OFS_CONTROL: read_byte = {1'b0, waveform_mode[0], output_action_mode,
			                                waveform_mode[1], clock_source_select};
			`TMR8_OFS_COUNT:   read_byte = count_value;
			`TMR8_OFS_COMPARE: read_byte = compare_value;
			`TMR8_OFS_MASK:    read_byte = {6'h00, match_irq_enable, overflow_irq_enable};
			`TMR8_OFS_FLAGS:   read_byte = {6'h00, match_flag, overflow_flag};
			default:           read_byte = 8'h00;
		endcase
	end

	// Read data is caught in the setup cycle so it comes from a flip-flop.
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			prdata_o <= 32'h0000_0000;
		else if (setup && !pwrite_i)
			prdata_o <= {24'h00_0000, read_byte};
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	// Control fields; the waveform bits are split as in the register layout.
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			waveform_mode       <= tmr8_wave_t'(2'b00);
			output_action_mode  <= tmr8_out_t'(2'(`TMR8_CONTROL_RST >> `TMR8_CTL_OUT_LO));
			clock_source_select <= tmr8_cs_t'(3'b000);
		end
		else if (wr_control)
		begin
			waveform_mode       <= tmr8_wave_t'({pwdata_i[`TMR8_CTL_WAVE_HI],
			                                     pwdata_i[`TMR8_CTL_WAVE_LO]});
			output_action_mode  <= tmr8_out_t'(pwdata_i[`TMR8_CTL_OUT_HI:`TMR8_CTL_OUT_LO]);
			clock_source_select <= tmr8_cs_t'(pwdata_i[`TMR8_CTL_CS_HI:0]);
		end
	end

	// The force strobe acts only in the non-PWM modes and raises no flag.
	assign force_match = wr_control && pwdata_i[`TMR8_CTL_FORCE] && !pwdata_i[`TMR8_CTL_WAVE_LO];

	// Compare value and interrupt enables.
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			compare_value       <= `TMR8_COMPARE_RST;
			match_irq_enable    <= 1'(`TMR8_MASK_RST >> `TMR8_BIT_MATCH);
			overflow_irq_enable <= 1'(`TMR8_MASK_RST >> `TMR8_BIT_OVF);
		end
		else
		begin
			if (wr_compare)
				compare_value <= pwdata_i[7:0];
			if (wr_mask)
			begin
				match_irq_enable    <= pwdata_i[`TMR8_BIT_MATCH];
				overflow_irq_enable <= pwdata_i[`TMR8_BIT_OVF];
			end
		end
	end

	// ************************************************************
	// Counter
	// ************************************************************
	// TOP is the compare value in CTC and the fixed maximum otherwise.
	assign top_value = (waveform_mode == TMR8_WAVE_CTC) ? compare_value : `TMR8_MAX;
	assign pwm_mode  = (waveform_mode == TMR8_WAVE_FAST) || (waveform_mode == TMR8_WAVE_DUAL);

	// Next count and direction on a timer tick.
	always_comb
	begin
		next_count = count_value;
		next_down  = count_down;
		if (tick)
		begin
			case (waveform_mode)
				TMR8_WAVE_CTC:
					next_count = (count_value == top_value) ? `TMR8_BOTTOM : count_value + 8'h01;
				TMR8_WAVE_DUAL:
					if (count_down && (count_value == `TMR8_BOTTOM))
					begin
						next_count = 8'h01;
						next_down  = 1'b0;
					end
					else if (!count_down && (count_value == `TMR8_MAX))
					begin
						next_count = `TMR8_MAX - 8'h01;
						next_down  = 1'b1;
					end
					else
						next_count = count_down ? count_value - 8'h01 : count_value + 8'h01;
				default:
					next_count = count_value + 8'h01;
			endcase
		end
	end

	// A software write wins over a tick in the same cycle.
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			count_value <= `TMR8_COUNT_RST;
			count_down  <= 1'b0;
		end
		else if (wr_count)
		begin
			count_value <= pwdata_i[7:0];
			count_down  <= count_down;
		end
		else
		begin
			count_value <= next_count;
			count_down  <= (waveform_mode == TMR8_WAVE_DUAL) ? next_down : 1'b0;
		end
	end

	// The block stays armed until the first tick after the write has passed.
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			match_block <= 1'b0;
		else if (wr_count)
			match_block <= 1'b1;
		else if (tick)
			match_block <= 1'b0;
	end

	// ************************************************************
	// Events
	// ************************************************************
	// The compare is evaluated every cycle; it only acts on a tick.
	assign match_hit  = tick && (count_value == compare_value) && !match_block;
	assign top_hit    = tick && (count_value == top_value);
	assign ovf_hit    = (waveform_mode == TMR8_WAVE_DUAL) ?
	                    (tick && count_down && (count_value == `TMR8_BOTTOM)) :
	                    (tick && (count_value == `TMR8_MAX));
	assign top_ignore = pwm_mode && (compare_value == `TMR8_MAX) &&
	                    output_action_mode[1];

	assign match_event_o  = match_hit;
	assign top_event_o    = top_hit;
	assign bottom_event_o = tick && (count_value == `TMR8_BOTTOM);

	// ************************************************************
	// Waveform output
	// ************************************************************
	// Action on the compare output register for the current mode.
	always_comb
	begin
		next_out = compare_out;
		case (waveform_mode)
			TMR8_WAVE_NORMAL, TMR8_WAVE_CTC:
				if (match_hit || force_match)
					case (output_action_mode)
						TMR8_OUT_TOGGLE: next_out = !compare_out;
						TMR8_OUT_CLEAR:  next_out = 1'b0;
						TMR8_OUT_SET:    next_out = 1'b1;
						default:         next_out = compare_out;
					endcase
			TMR8_WAVE_FAST:
				if (top_hit && output_action_mode[1])
					next_out = !output_action_mode[0];
				else if (match_hit && !top_ignore && output_action_mode[1])
					next_out = output_action_mode[0];
			TMR8_WAVE_DUAL:
				if (top_hit && top_ignore)
					next_out = !output_action_mode[0];
				else if (match_hit && !top_ignore && output_action_mode[1])
					next_out = output_action_mode[0] ^ count_down;
			default:
				next_out = compare_out;
		endcase
	end

	// Compare output register.
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			compare_out <= 1'b0;
		else
			compare_out <= next_out;
	end

	// Pin mux and driver enable; the direction bit alone gates the driver.
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			compare_output_pin_o    <= 1'b0;
			compare_output_pin_oe_o <= 1'b0;
		end
		else
		begin
			compare_output_pin_o    <= (output_action_mode != TMR8_OUT_OFF) ?
			                           compare_out : port_data_i;
			compare_output_pin_oe_o <= port_dir_i;
		end
	end

	// ************************************************************
	// Flags and interrupts
	// ************************************************************
	// A hardware set wins over a written one or an acknowledge in the same cycle.
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			match_flag    <= 1'(`TMR8_FLAGS_RST >> `TMR8_BIT_MATCH);
			overflow_flag <= 1'(`TMR8_FLAGS_RST >> `TMR8_BIT_OVF);
		end
		else
		begin
			if (match_hit)
				match_flag <= 1'b1;
			else if ((wr_flags && pwdata_i[`TMR8_BIT_MATCH]) || match_irq_ack_i)
				match_flag <= 1'b0;
			if (ovf_hit)
				overflow_flag <= 1'b1;
			else if ((wr_flags && pwdata_i[`TMR8_BIT_OVF]) || overflow_irq_ack_i)
				overflow_flag <= 1'b0;
		end
	end

	// Requests stay high while flag, enable and global enable are all set.
	assign match_irq_o    = match_flag && match_irq_enable && global_irq_enable_i;
	assign overflow_irq_o = overflow_flag && overflow_irq_enable && global_irq_enable_i;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking a_cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_count_written;
		wr_count ##1 tick;
	endsequence

	sequence s_dual_turn;
		(waveform_mode == TMR8_WAVE_DUAL) && tick && !wr_count && count_down &&
		(count_value == `TMR8_BOTTOM);
	endsequence

	a_pin_override: assert property (
		(output_action_mode != TMR8_OUT_OFF) |=> (compare_output_pin_o == $past(compare_out)))
		else $error("pin not taken by compare output");
	a_pin_driver_off: assert property (
		!port_dir_i |=> !compare_output_pin_oe_o)
		else $error("pin driver enabled while port is input");
	a_toggle_match: assert property (
		(!pwm_mode && (output_action_mode == TMR8_OUT_TOGGLE) && match_hit)
		|=> (compare_out != $past(compare_out)))
		else $error("toggle on match missing");
	a_fast_top_set: assert property (
		((waveform_mode == TMR8_WAVE_FAST) && (output_action_mode == TMR8_OUT_CLEAR) && top_hit)
		|=> compare_out)
		else $error("fast mode top did not set output");
	a_dual_down_set: assert property (
		((waveform_mode == TMR8_WAVE_DUAL) && (output_action_mode == TMR8_OUT_CLEAR) &&
		match_hit && count_down && !top_ignore) |=> compare_out)
		else $error("down-count match did not set output");
	a_top_ignore: assert property (
		(top_ignore && !top_hit) |=> (compare_out == $past(compare_out)))
		else $error("match acted although compare equals top");
	a_stopped: assert property (
		((clock_source_select == TMR8_CS_STOP) && !wr_count) |=> $stable(count_value))
		else $error("counter moved while stopped");
	a_count_write: assert property (
		wr_count |=> (count_value == $past(pwdata_i[7:0])))
		else $error("count write not stored");
	a_write_block: assert property (
		s_count_written |-> !match_hit)
		else $error("match not blocked after count write");
	a_match_flag: assert property (
		match_hit |=> match_flag ##1 (match_flag || $past(match_irq_ack_i) ||
		$past(wr_flags)))
		else $error("match flag not set");
	a_flag_ack: assert property (
		(match_irq_ack_i && !match_hit) |=> !match_flag)
		else $error("acknowledge did not clear match flag");
	a_dual_overflow: assert property (
		s_dual_turn |=> overflow_flag && (count_value == 8'h01) && !count_down)
		else $error("dual-slope turn at zero mishandled");
endmodule : tmr8_core
`default_nettype wire

//--- tmr8_params.svh
// Register offsets, field positions, reset values and counts of the 8-bit timer.
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH

// Byte offsets of the registers on the APB bus.
`define TMR8_ADDR_W        12
`define TMR8_OFS_CONTROL   12'h000
`define TMR8_OFS_COUNT     12'h004
`define TMR8_OFS_COMPARE   12'h008
`define TMR8_OFS_MASK      12'h00c
`define TMR8_OFS_FLAGS     12'h010

// Field positions in timer_control, interrupt_mask and interrupt_flags.
`define TMR8_CTL_FORCE     7
`define TMR8_CTL_WAVE_LO   6
`define TMR8_CTL_OUT_HI    5
`define TMR8_CTL_OUT_LO    4
`define TMR8_CTL_WAVE_HI   3
`define TMR8_CTL_CS_HI     2
`define TMR8_BIT_MATCH     1
`define TMR8_BIT_OVF       0

// Reset values.
`define TMR8_CONTROL_RST   8'h00
`define TMR8_COUNT_RST     8'h00
`define TMR8_COMPARE_RST   8'h00
`define TMR8_MASK_RST      8'h00
`define TMR8_FLAGS_RST     8'h00

// Counter limits and prescaler tap widths (divide by 8, 64, 256, 1024).
`define TMR8_MAX           8'hff
`define TMR8_BOTTOM        8'h00
`define TMR8_TAP8_BITS     3
`define TMR8_TAP64_BITS    6
`define TMR8_TAP256_BITS   8
`define TMR8_TAP1024_BITS  10

`endif

//--- tmr8_pkg.sv
// Types shared by the 8-bit timer modules.
`default_nettype none
package tmr8_pkg;
	// Waveform mode field.
	typedef enum logic [1:0] {
		TMR8_WAVE_NORMAL = 2'b00,
		TMR8_WAVE_DUAL   = 2'b01,
		TMR8_WAVE_CTC    = 2'b10,
		TMR8_WAVE_FAST   = 2'b11
	} tmr8_wave_t;
	// Clock source select field.
	typedef enum logic [2:0] {
		TMR8_CS_STOP     = 3'b000,
		TMR8_CS_DIV1     = 3'b001,
		TMR8_CS_DIV8     = 3'b010,
		TMR8_CS_DIV64    = 3'b011,
		TMR8_CS_DIV256   = 3'b100,
		TMR8_CS_DIV1024  = 3'b101,
		TMR8_CS_EXT_FALL = 3'b110,
		TMR8_CS_EXT_RISE = 3'b111
	} tmr8_cs_t;
	// Output action mode field.
	typedef enum logic [1:0] {
		TMR8_OUT_OFF    = 2'b00,
		TMR8_OUT_TOGGLE = 2'b01,
		TMR8_OUT_CLEAR  = 2'b10,
		TMR8_OUT_SET    = 2'b11
	} tmr8_out_t;
endpackage : tmr8_pkg
`default_nettype wire

//--- tmr8_tick_if.sv
// Interface between the timer core and its clock source selector.
`default_nettype none
`include "tmr8_params.svh"
interface tmr8_tick_if;
	import tmr8_pkg::*;
	tmr8_cs_t                        select;
	logic                            tick;
	logic [`TMR8_TAP1024_BITS-1:0]   prescale;
	modport core   (output select, input tick, input prescale);
	modport source (input select, output tick, output prescale);
endinterface : tmr8_tick_if
`default_nettype wire

//--- tmr8_clock_select.sv
// Shared prescaler, external count pin sampling and timer tick selection.
`default_nettype none
`include "tmr8_params.svh"
module tmr8_clock_select
	import tmr8_pkg::*;
(
	// Clock and reset.
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	// External count source and prescaler restart.
	input  wire logic external_count_pin_i,
	input  wire logic prescale_clear_i,
	// Tick bus towards the core.
	tmr8_tick_if.source tif
);
	logic [`TMR8_TAP1024_BITS-1:0] prescale;
	logic                          pin_s1;
	logic                          pin_s2;
	logic                          pin_s3;
	logic                          pin_level;
	logic                          pin_change;

	// Free-running prescaler; it ignores the clock select so several timers can tap it.
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			prescale <= '0;
		else if (prescale_clear_i)
			prescale <= '0;
		else
			prescale <= prescale + 10'h001;
	end
	assign tif.prescale = prescale;

	// Three-stage sampling; the pin is watched even when the port drives it.
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_s1    <= 1'b0;
			pin_s2    <= 1'b0;
			pin_s3    <= 1'b0;
			pin_level <= 1'b0;
		end
		else
		begin
			pin_s1 <= external_count_pin_i;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (pin_s2 == pin_s3)
				pin_level <= pin_s3;
		end
	end
	// A change counts only once the last two stages agree.
	assign pin_change = (pin_s2 == pin_s3) && (pin_s3 != pin_level);

	// Tick selection; prescaled taps fire when their low bits are all ones.
	always_comb
	begin
		case (tif.select)
			TMR8_CS_STOP:     tif.tick = 1'b0;
			TMR8_CS_DIV1:     tif.tick = 1'b1;
			TMR8_CS_DIV8:     tif.tick = &prescale[`TMR8_TAP8_BITS-1:0];
			TMR8_CS_DIV64:    tif.tick = &prescale[`TMR8_TAP64_BITS-1:0];
			TMR8_CS_DIV256:   tif.tick = &prescale[`TMR8_TAP256_BITS-1:0];
			TMR8_CS_DIV1024:  tif.tick = &prescale[`TMR8_TAP1024_BITS-1:0];
			TMR8_CS_EXT_FALL: tif.tick = pin_change && !pin_s3;
			TMR8_CS_EXT_RISE: tif.tick = pin_change && pin_s3;
			default:          tif.tick = 1'b0;
		endcase
	end
endmodule : tmr8_clock_select
`default_nettype wire

//--- tmr8_pin_model.sv
// Model of the port pin and of the external count source.
`default_nettype none
module tmr8_pin_model
(
	// Clock and reset.
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	// Pulse request and pin driver.
	input  wire logic pulse_i,
	input  wire logic pin_i,
	input  wire logic pin_oe_i,
	// Count pin and resolved pin level.
	output var  logic count_pin_o,
	output var  logic busy_o,
	output var  logic level_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] ph;
	logic       last;
	// Four cycles high and four low, so the pin sampler never misses a level.
	always_ff @(posedge core_clk_i or negedge rstn_i)
		if (!rstn_i)
			ph <= 3'h0;
		else if (pulse_i || ph != 3'h0)
			ph <= ph + 3'h1;
	assign count_pin_o = ph[2];
	assign busy_o = ph != 3'h0;
	// An undriven pin flips every cycle, so a stale value is never mistaken for drive.
	always_ff @(posedge core_clk_i)
		last <= level_o;
	assign level_o = pin_oe_i ? pin_i : ~last;
endmodule : tmr8_pin_model
`default_nettype wire

//--- testbench.sv
// Self-checking testbench of the 8-bit timer core.
`default_nettype none
`include "tmr8_params.svh"
`define CHK(g, x) begin #1; checks_done++; if ((g) !== (x)) begin n_errors++; $display("mismatch at %0t: %h not %h", $time, (g), (x)); end end
module testbench
	import tmr8_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] ct = `TMR8_OFS_CONTROL;
	localparam logic [11:0] cn = `TMR8_OFS_COUNT;
	localparam logic [11:0] cp = `TMR8_OFS_COMPARE;
	localparam logic [11:0] fl = `TMR8_OFS_FLAGS;
	logic clk, rstn, psel, penable, pwrite, dir, dat, pclr, gie, mack, oack, pulse;
	logic [11:0] paddr;
	logic [9:0] pcnt;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr, pin, oe, mirq, oirq, cpin, busy, lvl, e, mev, tev, bev;
	int n_errors, checks_done, i, k, nm, nt, nb, m0, t0, b0;
	int dv[4] = '{8, 64, 256, 1024};
	tmr8_cs_t cs[4] = '{TMR8_CS_DIV8, TMR8_CS_DIV64, TMR8_CS_DIV256, TMR8_CS_DIV1024};
	tmr8_out_t o;
	tmr8_core tmr8_core_inst (.core_clk_i(clk), .rstn_i(rstn), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .port_dir_i(dir),
		.port_data_i(dat), .compare_output_pin_o(pin), .compare_output_pin_oe_o(oe),
		.external_count_pin_i(cpin), .prescale_clear_i(pclr), .prescale_count_o(pcnt),
		.global_irq_enable_i(gie), .match_irq_ack_i(mack), .overflow_irq_ack_i(oack),
		.match_irq_o(mirq), .overflow_irq_o(oirq), .match_event_o(mev), .top_event_o(tev),
		.bottom_event_o(bev));
	tmr8_pin_model tmr8_pin_model_inst (.core_clk_i(clk), .rstn_i(rstn), .pulse_i(pulse),
		.pin_i(pin), .pin_oe_i(oe), .count_pin_o(cpin), .busy_o(busy), .level_o(lvl));
	// Free running 10 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Event pulses are counted at every rising edge; scenarios compare differences.
	always @(posedge clk)
	begin
		nm <= nm + int'(mev);
		nt <= nt + int'(tev);
		nb <= nb + int'(bev);
	end
	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int j;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		for (j = 0; j < 16; j++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (j == 16)
		begin
			n_errors++;
			conclude();
		end
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 8'h00);
		`CHK(r, x)
	endtask : rd
	task automatic run(input int n);
		repeat (n) @(posedge clk);
	endtask : run
	// One external count pulse, then time for the pin synchroniser to pass it on.
	task automatic kick();
		int j;
		@(posedge clk);
		pulse <= 1'b1;
		@(posedge clk);
		pulse <= 1'b0;
		for (j = 0; j < 20; j++)
		begin
			@(posedge clk);
			#1;
			if (busy === 1'b0)
				break;
		end
		if (j == 20)
		begin
			`CHK(busy, 1'b0)
			conclude();
		end
		run(5);
	endtask : kick
	function automatic logic [7:0] ctl(tmr8_wave_t w, tmr8_out_t m, tmr8_cs_t c);
		return {1'b0, w[0], m, w[1], c};
	endfunction : ctl
	// ****************************************
	// Main sequence.
	// ****************************************
	initial
	begin
		{rstn, psel, penable, pwrite, dat, pclr, gie, mack, oack, pulse} = '0;
		{paddr, pwdata} = '0;
		dir = 1'b1;
		n_errors = 0;
		checks_done = 0;
		run(6);
		rstn <= 1'b1;
		for (k = 0; k < 5; k++)
			rd(12'(k * 4), 32'h0);
		apb(1'b0, 12'h014, 8'h00);
		`CHK({e, r}, 33'h100000000)
		wr(cn, 8'h5a);
		rd(cn, 32'h5a);
		wr(ct, ctl(TMR8_WAVE_FAST, TMR8_OUT_SET, TMR8_CS_STOP) | 8'h80);
		rd(ct, 32'h78);
		// Counts are also written while an external source is selected; the write blocks the match on the next tick.
		wr(ct, ctl(TMR8_WAVE_NORMAL, TMR8_OUT_OFF, TMR8_CS_EXT_RISE));
		wr(cp, 8'h05);
		wr(cn, 8'h05);
		wr(fl, 8'h03);
		kick();
		rd(cn, 32'h06);
		rd(fl, 32'h00);
		wr(ct, ctl(TMR8_WAVE_NORMAL, TMR8_OUT_OFF, TMR8_CS_EXT_FALL));
		wr(cp, 8'h06);
		kick();
		rd(cn, 32'h07);
		rd(fl, 32'h02);
		wr(`TMR8_OFS_MASK, 8'h03);
		gie <= 1'b1;
		`CHK({mirq, oirq}, 2'b10)
		@(posedge clk) gie <= 1'b0;
		`CHK(mirq, 1'b0)
		@(posedge clk) mack <= 1'b1;
		@(posedge clk) mack <= 1'b0;
		rd(fl, 32'h00);
		wr(cn, 8'h00);
		wr(cp, 8'h10);
		for (k = 0; k < 2; k++)
		begin
			o = k == 0 ? TMR8_OUT_SET : TMR8_OUT_CLEAR;
			wr(ct, ctl(TMR8_WAVE_NORMAL, o, TMR8_CS_DIV1));
			run(300);
			wr(ct, ctl(TMR8_WAVE_NORMAL, o, TMR8_CS_STOP));
			`CHK({oe, lvl}, {1'b1, k == 0})
			rd(fl, 32'h03);
			wr(fl, 8'h03);
			rd(fl, 32'h00);
		end
		wr(ct, ctl(TMR8_WAVE_NORMAL, TMR8_OUT_OFF, TMR8_CS_STOP));
		dat <= 1'b1;
		run(1);
		`CHK(lvl, 1'b1)
		@(posedge clk) {dat, dir} <= 2'b00;
		run(1);
		`CHK(oe, 1'b0)
		@(posedge clk) dir <= 1'b1;
		wr(cp, 8'hff);
		for (k = 0; k < 2; k++)
		begin
			o = k == 0 ? TMR8_OUT_CLEAR : TMR8_OUT_SET;
			wr(ct, ctl(TMR8_WAVE_FAST, o, TMR8_CS_DIV1));
			run(300);
			repeat (6)
			begin
				run(41);
				`CHK(lvl, k == 0)
			end
		end
		wr(fl, 8'h03);
		wr(ct, ctl(TMR8_WAVE_DUAL, TMR8_OUT_CLEAR, TMR8_CS_DIV1));
		run(600);
		wr(ct, ctl(TMR8_WAVE_DUAL, TMR8_OUT_CLEAR, TMR8_CS_STOP));
		rd(fl, 32'h03);
		@(posedge clk) oack <= 1'b1;
		@(posedge clk) oack <= 1'b0;
		rd(fl, 32'h02);
		{m0, t0, b0} = {nm, nt, nb};
		for (k = 0; k < 4; k++)
		begin
			wr(cn, 8'h00);
			pclr <= 1'b1;
			wr(ct, ctl(TMR8_WAVE_NORMAL, TMR8_OUT_OFF, cs[k]));
			pclr <= 1'b0;
			`CHK(pcnt, 10'h000)
			run(4 * dv[k]);
			wr(ct, 8'h00);
			rd(cn, 32'h4);
		end
		`CHK({nm - m0, nt - t0, nb - b0}, {32'd0, 32'd0, 32'd4})
		conclude();
	end
endmodule : testbench
`default_nettype wire
